/* File: hdl/bst_link_if.sv */
// Synchronised test port signals passed from the sampler to the controller
`timescale 1ns/1ns
`default_nettype none
`include "bst_params.svh"
interface bst_link_if;
   logic                    tck_rise;
   logic                    tck_fall;
   logic                    tms;
   logic                    tdi;
   logic [`BST_BSR_LEN-1:0] pins;
   modport src (output tck_rise, output tck_fall, output tms,
                output tdi, output pins);
   modport dst (input tck_rise, input tck_fall, input tms,
                input tdi, input pins);
endinterface
`default_nettype wire

/* File: hdl/bst_params.svh */
// Constants for the boundary-scan test port instruction logic
// Notes on behaviour
// - Capture-IR loads 01 into the two low instruction bits.
// - Shift-IR puts instruction register between serial in and out.
// - New instruction acts only after Update-IR; old one stays before.
// - Codes are MSB left, LSB right; both ends read them alike.
// - Code 000 selects external test with the boundary register.
// - External test never blocks the memory's functional inputs.
// - External test drives boundary contents out on TCK fall in Update-IR.
// - External test captures all pin levels and defaults in Capture-DR.
// - Identification code captures ROM in Capture-DR, shifts in Shift-DR.
// - Code 001 loads at power-up and in Test-Logic-Reset.
// - Code 010 forces outputs high-Z, captures ring, shifts boundary.
// - Code 100 captures buffer levels then shifts boundary register.
// - Cells without a pin capture their fixed default value.
// - Code 111 puts the one-bit bypass register in Shift-DR.
// - Instruction register is three bits wide.
// - Identification register is 32 bits, bit 0 shifted out first.
// - Five TMS-high rising edges reach Test-Logic-Reset; also power-up.
// - Inputs sampled on TCK rise; serial output changes on TCK fall.
`ifndef BST_PARAMS_SVH
`define BST_PARAMS_SVH

`define BST_IR_W        3
`define BST_IR_CAPT     3'h1
`define BST_OP_EXTEST   3'h0
`define BST_OP_IDCODE   3'h1
`define BST_OP_SAMPZ    3'h2
`define BST_OP_SAMPLE   3'h4
`define BST_OP_BYPASS   3'h7
`define BST_ID_W        32
// Maker and part fields are arbitrary neutral values
`define BST_ID_MAKER    11'h2A5
`define BST_ID_PART     20'h0C0DE
`define BST_ID_FIXED    1'h1
`define BST_BSR_LEN     8
`define BST_BSR_PINMASK 8'h7F
`define BST_BSR_DEFLT   8'hFF
`define BST_TLR_ONES    3'h5
`define BST_ONES_W      3
`define BST_SYNC_N      (`BST_BSR_LEN + 3)

`endif

/* File: hdl/bst_pkg.sv */
// Types shared by the test port modules
`default_nettype none
package bst_pkg;
   // Controller states, Gray steps along the common path
   typedef enum logic [3:0] {
      BST_TLR     = 4'h0,
      BST_RTI     = 4'h1,
      BST_SEL_DR  = 4'h3,
      BST_CAP_DR  = 4'h2,
      BST_SH_DR   = 4'h6,
      BST_EX1_DR  = 4'h7,
      BST_PAU_DR  = 4'h5,
      BST_EX2_DR  = 4'h4,
      BST_UPD_DR  = 4'hC,
      BST_SEL_IR  = 4'hD,
      BST_CAP_IR  = 4'hF,
      BST_SH_IR   = 4'hE,
      BST_EX1_IR  = 4'hA,
      BST_PAU_IR  = 4'hB,
      BST_EX2_IR  = 4'h9,
      BST_UPD_IR  = 4'h8
   } bst_state_t;
endpackage
`default_nettype wire

/* File: hdl/bst_sync.sv */
// Three-stage input sampler and TCK edge finder for the test port
`timescale 1ns/1ns
`default_nettype none
`include "bst_params.svh"
module bst_sync
   import bst_pkg::*;
(
   input  wire logic                    clock,
   input  wire logic                    nrst,
   input  wire logic                    tck,
   input  wire logic                    tms,
   input  wire logic                    tdi,
   input  wire logic [`BST_BSR_LEN-1:0] pin_level,
   bst_link_if.src                      lk
);
   logic [`BST_SYNC_N-1:0] raw;
   logic [`BST_SYNC_N-1:0] s1_q;
   logic [`BST_SYNC_N-1:0] s2_q;
   logic [`BST_SYNC_N-1:0] s3_q;
   logic [`BST_SYNC_N-1:0] flt_q;
   logic                   tck_prev_q;

   assign raw = {pin_level, tdi, tms, tck};

   // A level is accepted only once stages two and three agree,
   // which hides a single metastable sample from the controller
   genvar i;
   generate
      for (i = 0; i < `BST_SYNC_N; i = i + 1) begin : g_bit
         always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
               s1_q[i]  <= 1'h0;
               s2_q[i]  <= 1'h0;
               s3_q[i]  <= 1'h0;
               flt_q[i] <= 1'h0;
            end else begin
               s1_q[i] <= raw[i];
               s2_q[i] <= s1_q[i];
               s3_q[i] <= s2_q[i];
               if (s2_q[i] == s3_q[i]) flt_q[i] <= s3_q[i];
            end
         end
      end
   endgenerate

   // Previous filtered TCK for edge finding
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) tck_prev_q <= 1'h0;
      else       tck_prev_q <= flt_q[0];
   end

   assign lk.tck_rise = flt_q[0] & ~tck_prev_q;
   assign lk.tck_fall = ~flt_q[0] & tck_prev_q;
   assign lk.tms      = flt_q[1];
   assign lk.tdi      = flt_q[2];
   assign lk.pins     = flt_q[`BST_SYNC_N-1:3];
endmodule
`default_nettype wire

/* File: hdl/bst_tap.sv */
// Test access port controller with instruction decode and scan registers
`timescale 1ns/1ns
`default_nettype none
`include "bst_params.svh"
module bst_tap
   import bst_pkg::*;
(
   input  wire logic                    clock,
   input  wire logic                    nrst,
   input  wire logic                    tck,
   input  wire logic                    tms,
   input  wire logic                    tdi,
   output logic                         tdo,
   output logic                         tdo_oe,
   input  wire logic [`BST_BSR_LEN-1:0] pin_level,
   output logic                         mem_out_hiz,
   output logic                         mem_out_override,
   output logic [`BST_BSR_LEN-1:0]      mem_out_value,
   output logic [`BST_ID_W-1:0]         device_identification
);
   bst_link_if lk ();

   bst_sync u_sync (
      .clock     (clock),
      .nrst      (nrst),
      .tck       (tck),
      .tms       (tms),
      .tdi       (tdi),
      .pin_level (pin_level),
      .lk        (lk.src)
   );

   bst_state_t                state_q;
   bst_state_t                state_d;
   logic [`BST_IR_W-1:0]      ir_sh_q;
   logic [`BST_IR_W-1:0]      ir_q;
   logic                      byp_q;
   logic [`BST_ID_W-1:0]      idr_q;
   logic [`BST_BSR_LEN-1:0]   bsr_q;
   logic [`BST_BSR_LEN-1:0]   bsr_upd_q;
   logic                      tdo_q;
   logic                      tdo_oe_q;
   logic [`BST_ONES_W-1:0]    ones_q;

   // Instruction decode; unlisted private codes fall to bypass
   wire is_ext   = (ir_q == `BST_OP_EXTEST);
   wire is_id    = (ir_q == `BST_OP_IDCODE);
   wire is_sampz = (ir_q == `BST_OP_SAMPZ);
   wire is_samp  = (ir_q == `BST_OP_SAMPLE);
   wire sel_bsr  = is_ext | is_sampz | is_samp;
   wire sel_id   = is_id;
   wire sel_byp  = ~sel_bsr & ~sel_id;
   wire new_ext  = (ir_sh_q == `BST_OP_EXTEST);

   // Fixed identification pattern and boundary capture value
   wire [`BST_ID_W-1:0] id_rom =
      {`BST_ID_PART, `BST_ID_MAKER, `BST_ID_FIXED};
   wire [`BST_BSR_LEN-1:0] bsr_cap =
      (lk.pins & `BST_BSR_PINMASK) |
      (`BST_BSR_DEFLT & ~`BST_BSR_PINMASK);

   // Serial output source: instruction path or selected data register
   wire sh_ir = (state_q == BST_SH_IR);
   wire sh_dr = (state_q == BST_SH_DR);
   wire ser_bit = sh_ir   ? ir_sh_q[0] :
                  sel_id  ? idr_q[0]   :
                  sel_byp ? byp_q      : bsr_q[0];

   // Controller next state on TMS
   always_comb begin
      case (state_q)
         BST_TLR:    state_d = lk.tms ? BST_TLR    : BST_RTI;
         BST_RTI:    state_d = lk.tms ? BST_SEL_DR : BST_RTI;
         BST_SEL_DR: state_d = lk.tms ? BST_SEL_IR : BST_CAP_DR;
         BST_CAP_DR: state_d = lk.tms ? BST_EX1_DR : BST_SH_DR;
         BST_SH_DR:  state_d = lk.tms ? BST_EX1_DR : BST_SH_DR;
         BST_EX1_DR: state_d = lk.tms ? BST_UPD_DR : BST_PAU_DR;
         BST_PAU_DR: state_d = lk.tms ? BST_EX2_DR : BST_PAU_DR;
         BST_EX2_DR: state_d = lk.tms ? BST_UPD_DR : BST_SH_DR;
         BST_UPD_DR: state_d = lk.tms ? BST_SEL_DR : BST_RTI;
         BST_SEL_IR: state_d = lk.tms ? BST_TLR    : BST_CAP_IR;
         BST_CAP_IR: state_d = lk.tms ? BST_EX1_IR : BST_SH_IR;
         BST_SH_IR:  state_d = lk.tms ? BST_EX1_IR : BST_SH_IR;
         BST_EX1_IR: state_d = lk.tms ? BST_UPD_IR : BST_PAU_IR;
         BST_PAU_IR: state_d = lk.tms ? BST_EX2_IR : BST_PAU_IR;
         BST_EX2_IR: state_d = lk.tms ? BST_UPD_IR : BST_SH_IR;
         BST_UPD_IR: state_d = lk.tms ? BST_SEL_DR : BST_RTI;
         default:    state_d = BST_TLR;
      endcase
   end

   // State advances on TCK rise; no test reset pin, so power-up
   // reset and the TMS-high walk are the only ways home
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst)            state_q <= BST_TLR;
      else if (lk.tck_rise) state_q <= state_d;
   end

   // Instruction shift path, captured and shifted on TCK rise
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ir_sh_q <= `BST_IR_CAPT;
      end else if (lk.tck_rise) begin
         if (state_q == BST_CAP_IR)
            ir_sh_q <= `BST_IR_CAPT;
         else if (sh_ir)
            ir_sh_q <= {lk.tdi, ir_sh_q[`BST_IR_W-1:1]};
      end
   end

   // Active instruction changes only on TCK fall in Update-IR,
   // or returns to the identification code in Test-Logic-Reset
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         ir_q <= `BST_OP_IDCODE;
      end else if (lk.tck_fall) begin
         if (state_q == BST_TLR)
            ir_q <= `BST_OP_IDCODE;
         else if (state_q == BST_UPD_IR)
            ir_q <= ir_sh_q;
      end
   end

   // Bypass bit: zero on capture, one stage on shift
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         byp_q <= 1'h0;
      end else if (lk.tck_rise && sel_byp) begin
         if (state_q == BST_CAP_DR) byp_q <= 1'h0;
         else if (sh_dr)            byp_q <= lk.tdi;
      end
   end

   // Identification register, low bit leaves first
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         idr_q <= '0;
      end else if (lk.tck_rise && sel_id) begin
         if (state_q == BST_CAP_DR)
            idr_q <= id_rom;
         else if (sh_dr)
            idr_q <= {lk.tdi, idr_q[`BST_ID_W-1:1]};
      end
   end

   // Boundary register; capture is only trustworthy if the memory
   // inputs hold still across the sample, which the board must ensure
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         bsr_q <= '0;
      end else if (lk.tck_rise && sel_bsr) begin
         if (state_q == BST_CAP_DR)
            bsr_q <= bsr_cap;
         else if (sh_dr)
            bsr_q <= {lk.tdi, bsr_q[`BST_BSR_LEN-1:1]};
      end
   end

   // Parallel output stage for external test, updated on TCK fall
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         bsr_upd_q <= '0;
      end else if (lk.tck_fall) begin
         if (state_q == BST_UPD_IR && new_ext)
            bsr_upd_q <= bsr_q;
         else if (state_q == BST_UPD_DR && sel_bsr)
            bsr_upd_q <= bsr_q;
      end
   end

   // Serial output moves only on TCK fall, driven while shifting
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         tdo_q    <= 1'h0;
         tdo_oe_q <= 1'h0;
      end else if (lk.tck_fall) begin
         tdo_q    <= ser_bit;
         tdo_oe_q <= sh_ir | sh_dr;
      end
   end

   // Run of TMS-high rising edges, used by a check below
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst)
         ones_q <= '0;
      else if (lk.tck_rise)
         ones_q <= !lk.tms ? '0 :
                   (ones_q == `BST_TLR_ONES) ? ones_q : ones_q + 3'h1;
   end

   // Outputs; functional inputs are never gated here
   assign tdo                   = tdo_q;
   assign tdo_oe                = tdo_oe_q;
   assign mem_out_hiz           = is_sampz;
   assign mem_out_override      = is_ext;
   assign mem_out_value         = bsr_upd_q;
   assign device_identification = idr_q;

   capture_ir_a: assert property (
      @(posedge clock) disable iff (!nrst)
      lk.tck_rise && state_q == BST_CAP_IR |=> ir_sh_q[1:0] == 2'h1)
      else $error("capture-IR did not load 01");

   ir_hold_a: assert property (
      @(posedge clock) disable iff (!nrst)
      !(lk.tck_fall && (state_q == BST_UPD_IR || state_q == BST_TLR))
      |=> $stable(ir_q))
      else $error("instruction changed outside update");

   ir_update_a: assert property (
      @(posedge clock) disable iff (!nrst)
      lk.tck_fall && state_q == BST_UPD_IR |=> ir_q == $past(ir_sh_q))
      else $error("update-IR did not take shifted code");

   tlr_idcode_a: assert property (
      @(posedge clock) disable iff (!nrst)
      lk.tck_fall && state_q == BST_TLR |=> ir_q == `BST_OP_IDCODE)
      else $error("reset state did not load identification code");

   tms_reset_a: assert property (
      @(posedge clock) disable iff (!nrst)
      lk.tck_rise && lk.tms && ones_q == (`BST_TLR_ONES - 3'h1)
      |=> state_q == BST_TLR)
      else $error("five TMS-high edges did not reach reset");

   id_capture_a: assert property (
      @(posedge clock) disable iff (!nrst)
      lk.tck_rise && state_q == BST_CAP_DR && sel_id
      |=> idr_q == id_rom && idr_q[0] == 1'h1)
      else $error("identification capture wrong");

   bypass_cap_a: assert property (
      @(posedge clock) disable iff (!nrst)
      lk.tck_rise && state_q == BST_CAP_DR && sel_byp |=> byp_q == 1'h0)
      else $error("bypass capture not zero");

   bsr_default_a: assert property (
      @(posedge clock) disable iff (!nrst)
      lk.tck_rise && state_q == BST_CAP_DR && sel_bsr
      |=> (bsr_q & ~`BST_BSR_PINMASK) ==
          (`BST_BSR_DEFLT & ~`BST_BSR_PINMASK))
      else $error("unpinned boundary cells lost default");

   tdo_edge_a: assert property (
      @(posedge clock) disable iff (!nrst)
      !lk.tck_fall |=> $stable(tdo_q) && $stable(tdo_oe_q))
      else $error("serial output moved off a TCK fall");

   hiz_sel_a: assert property (
      @(posedge clock) disable iff (!nrst)
      ir_q == `BST_OP_SAMPZ |-> mem_out_hiz && !mem_out_override)
      else $error("sample-Z did not force high impedance");

   // Scan path checks look one clock after the sampled TCK edge, when
   // the register that moved on that edge has settled
   ir_shift_a: assert property (
      @(posedge clock) disable iff (!nrst)
      lk.tck_rise && sh_ir
      |=> ir_sh_q == {$past(lk.tdi), $past(ir_sh_q[`BST_IR_W-1:1])})
      else $error("instruction shift path wrong");

   id_shift_a: assert property (
      @(posedge clock) disable iff (!nrst)
      lk.tck_rise && sh_dr && sel_id
      |=> idr_q == {$past(lk.tdi), $past(idr_q[`BST_ID_W-1:1])})
      else $error("identification shift wrong");

   bypass_shift_a: assert property (
      @(posedge clock) disable iff (!nrst)
      lk.tck_rise && sh_dr && sel_byp |=> byp_q == $past(lk.tdi))
      else $error("bypass stage did not pass serial input");

   bsr_shift_a: assert property (
      @(posedge clock) disable iff (!nrst)
      lk.tck_rise && sh_dr && sel_bsr
      |=> bsr_q == {$past(lk.tdi), $past(bsr_q[`BST_BSR_LEN-1:1])})
      else $error("boundary shift wrong");

   // Pinned cells must take the sampled level, not a stale one
   bsr_capture_a: assert property (
      @(posedge clock) disable iff (!nrst)
      lk.tck_rise && state_q == BST_CAP_DR && sel_bsr
      |=> (bsr_q & `BST_BSR_PINMASK) ==
          ($past(lk.pins) & `BST_BSR_PINMASK))
      else $error("boundary capture missed a pin level");

   ext_update_a: assert property (
      @(posedge clock) disable iff (!nrst)
      lk.tck_fall && state_q == BST_UPD_IR && new_ext
      |=> mem_out_value == $past(bsr_q))
      else $error("external test did not drive boundary contents");

   // Enable follows the shift states so a released line reads as idle
   serial_enable_a: assert property (
      @(posedge clock) disable iff (!nrst)
      lk.tck_fall |=> tdo_oe == $past(sh_ir | sh_dr))
      else $error("serial enable out of step with shift states");

   sel_ir_exit_a: assert property (
      @(posedge clock) disable iff (!nrst)
      lk.tck_rise && state_q == BST_SEL_IR && lk.tms
      |=> state_q == BST_TLR)
      else $error("mode high in select-IR did not reach reset");
endmodule
`default_nettype wire

/* File: verif/bst_jtag_ctl.sv */
// Behavioural test controller that drives the serial test port
`timescale 1ns/1ns
`default_nettype none
module bst_jtag_ctl (
   input  wire logic clock,
   output var logic  tck,
   output var logic  tms,
   output var logic  tdi,
   input  wire logic tdo,
   input  wire logic tdo_oe
);
   int   stall;    // Extra low-phase clocks, so the port is also run slowly
   int   edge_bad; // Serial output seen moving while the test clock was high
   logic early;

   // A released serial line shows the inverse, so an enable that drops
   // too early corrupts the read bit instead of hiding it
   wire logic tdo_seen = tdo_oe ? tdo : ~tdo;

   // Test clock stands low between frames, mode high as after power-up
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
      stall = 0;
      edge_bad = 0;
   end

   // One test clock: inputs set while low, output read late in high phase
   task automatic step(input logic m, input logic d, output logic q);
      @(negedge clock);
      tms = m;
      tdi = d;
      repeat (3 + stall) @(negedge clock);
      tck = 1'b1;
      @(negedge clock);
      early = tdo_seen;
      repeat (3) @(negedge clock);
      q = tdo_seen;
      if (early !== q) edge_bad++;
      tck = 1'b0;
   endtask

   // Five mode-high clocks reach reset from any state, then go idle
   task automatic go_reset();
      logic q;
      repeat (5) step(1'b1, ~tdi, q);
      step(1'b0, ~tdi, q);
   endtask

   // Idle to Pause-IR with a new code shifted in, low bit first
   task automatic ir_load(input logic [2:0] code, output logic [2:0] old);
      logic q;
      step(1'b1, ~tdi, q);
      step(1'b1, ~tdi, q);
      step(1'b0, ~tdi, q);
      step(1'b0, ~tdi, q);
      for (int i = 0; i < 3; i++) begin
         step(i == 2, code[i], q);
         old[i] = q;
      end
      step(1'b0, ~tdi, q);
   endtask

   // Pause-IR through Update-IR and back to idle
   task automatic ir_done();
      logic q;
      step(1'b1, ~tdi, q);
      step(1'b1, ~tdi, q);
      step(1'b0, ~tdi, q);
   endtask

   // Idle through capture, n shift clocks and update back to idle
   task automatic dr_shift(input int n, input logic [31:0] din,
                           output logic [31:0] dout);
      logic q;
      dout = '0;
      step(1'b1, ~tdi, q);
      step(1'b0, ~tdi, q);
      step(1'b0, ~tdi, q);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], q);
         dout[i] = q;
      end
      step(1'b1, ~tdi, q);
      step(1'b0, ~tdi, q);
   endtask
endmodule
`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking bench for the test port instruction logic
`timescale 1ns/1ns
`default_nettype none
`include "bst_params.svh"
module tb_top;
   import bst_pkg::*;
   localparam int BL = `BST_BSR_LEN;
   localparam logic [31:0] ID_EXP = {`BST_ID_PART, `BST_ID_MAKER,
                                     `BST_ID_FIXED};
   logic          clock, nrst, tck, tms, tdi, tdo, tdo_oe, hiz, ovr;
   logic [BL-1:0] pin_level, out_val, bsr_m;
   logic [31:0]   id_q, din, dout;
   logic [2:0]    old, act_m, code;
   int            n_errors, checks, cycles, seed;

   bst_tap i_dut (.clock(clock), .nrst(nrst), .tck(tck), .tms(tms),
      .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe), .pin_level(pin_level),
      .mem_out_hiz(hiz), .mem_out_override(ovr), .mem_out_value(out_val),
      .device_identification(id_q));
   bst_jtag_ctl i_ctl (.clock(clock), .tck(tck), .tms(tms), .tdi(tdi),
      .tdo(tdo), .tdo_oe(tdo_oe));

   // Free-running system clock
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   // Hang guard, well above the few thousand clocks the run needs
   always @(posedge clock) begin
      cycles++;
      if (cycles > 40000) begin
         n_errors++;
         give_verdict();
      end
   end

   task automatic cmp_word(input string nm, input logic [31:0] e,
                           input logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic cmp_flag(input string nm, input logic e, input logic g);
      checks++;
      if (g !== e) begin
         n_errors++;
         $display("BAD %s expected %b seen %b", nm, e, g);
      end
   endtask

   // Boundary instructions use the 8-cell chain, all others 32 clocks
   function automatic logic is_bnd(input logic [2:0] c);
      return c == `BST_OP_EXTEST || c == `BST_OP_SAMPZ ||
             c == `BST_OP_SAMPLE;
   endfunction

   // Expected scan-out of the selected data register under a code
   function automatic logic [31:0] dr_model(input logic [2:0] c,
      input logic [31:0] d, input logic [BL-1:0] p);
      logic [BL-1:0] cap;
      cap = (p & `BST_BSR_PINMASK) | (`BST_BSR_DEFLT & ~`BST_BSR_PINMASK);
      if (c == `BST_OP_IDCODE) return ID_EXP;
      if (is_bnd(c)) return {24'h0, cap};
      return {d[30:0], 1'b0};
   endfunction

   // Capture, shift and update the selected data register
   task automatic dr_run();
      int          n;
      logic [31:0] r;
      n = is_bnd(act_m) ? BL : 32;
      @(negedge clock);
      din = $random(seed);
      r = $random(seed);
      pin_level = r[BL-1:0];
      i_ctl.stall = $unsigned($random(seed)) % 3;
      i_ctl.dr_shift(n, din, dout);
      cmp_word("scan out", dr_model(act_m, din, pin_level), dout);
      cmp_flag("serial enable idle", 1'b0, tdo_oe);
      if (act_m == `BST_OP_IDCODE)
         cmp_word("device_identification", din, id_q);
      if (n == BL) bsr_m = din[BL-1:0];
      if (n == BL && act_m == `BST_OP_EXTEST)
         cmp_word("update out", {24'h0, bsr_m}, {24'h0, out_val});
   endtask

   // Load a code; the old one must rule until Update-IR
   task automatic ir_run(input logic [2:0] c);
      i_ctl.ir_load(c, old);
      cmp_word("ir capture", {29'h0, `BST_IR_CAPT}, {29'h0, old});
      cmp_flag("hiz held", act_m == `BST_OP_SAMPZ, hiz);
      cmp_flag("override held", act_m == `BST_OP_EXTEST, ovr);
      i_ctl.ir_done();
      act_m = c;
      cmp_flag("hiz", c == `BST_OP_SAMPZ, hiz);
      cmp_flag("override", c == `BST_OP_EXTEST, ovr);
      if (c == `BST_OP_EXTEST)
         cmp_word("parallel out", {24'h0, bsr_m}, {24'h0, out_val});
   endtask

   task automatic give_verdict();
      if (n_errors == 0 && checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      seed = 32'h937b;
      n_errors = 0;
      checks = 0;
      cycles = 0;
      nrst = 1'b0;
      pin_level = '0;
      act_m = `BST_OP_IDCODE;
      bsr_m = '0;
      repeat (5) @(negedge clock);
      nrst = 1'b1;
      cmp_flag("reset hiz", 1'b0, hiz);
      cmp_word("reset id", 32'h0, id_q);
      i_ctl.go_reset();
      dr_run();
      ir_run(`BST_OP_SAMPLE);
      dr_run();
      dr_run();
      ir_run(`BST_OP_EXTEST);
      dr_run();
      ir_run(`BST_OP_SAMPZ);
      dr_run();
      for (int k = 1; k < 8; k++) begin
         code = k[2:0];
         ir_run(code);
         dr_run();
      end
      repeat (6) begin
         din = $random(seed);
         code = din[2:0];
         ir_run(code);
         dr_run();
      end
      ir_run(`BST_OP_SAMPZ);
      i_ctl.go_reset();
      act_m = `BST_OP_IDCODE;
      cmp_flag("hiz after reset", 1'b0, hiz);
      dr_run();
      cmp_word("edge moves", 32'h0, i_ctl.edge_bad);
      give_verdict();
   end
endmodule
`default_nettype wire
